/* hw/ufdc_cfg.svh */
// Constants for the FIFO control and DMA ready block.
`ifndef UFDC_CFG_SVH
`define UFDC_CFG_SVH
`define UFDC_DEPTH         7'd64
`define UFDC_HOLD_DEPTH    7'd1
`define UFDC_FC_RESET      8'h00
`define UFDC_FC_SELFCLR    8'hf9
`define UFDC_LS_RESET      8'h60
`define UFDC_FC_EN         0
`define UFDC_FC_RXCLR      1
`define UFDC_FC_TXCLR      2
`define UFDC_FC_DMA        3
`define UFDC_FC_TXTRIG_LO  4
`define UFDC_FC_TXTRIG_HI  5
`define UFDC_FC_RXTRIG_LO  6
`define UFDC_FC_RXTRIG_HI  7
`define UFDC_RXTRIG_0      7'd8
`define UFDC_RXTRIG_1      7'd16
`define UFDC_RXTRIG_2      7'd56
`define UFDC_RXTRIG_3      7'd60
`define UFDC_TXTRIG_0      7'd8
`define UFDC_TXTRIG_1      7'd16
`define UFDC_TXTRIG_2      7'd32
`define UFDC_TXTRIG_3      7'd56
`define UFDC_ISR_NONE      6'h01
`define UFDC_ISR_RXDATA    6'h04
`define UFDC_ISR_RXTOUT    6'h0c
`define UFDC_ISR_TXEMPTY   6'h02
`endif

/* hw/ufdc_fifo_dma_control.sv */
// FIFO control, trigger levels, DMA ready pins and status for one UART channel.
//
// Overview of operation
// - With FIFOs and receive interrupt on, interrupt while receive count reaches trigger.
// - Receive trigger status code in interrupt_source clears together with the interrupt.
// - line_status bit 0 sets when a character enters receive FIFO, clears when empty.
// - FIFOs on and interrupt_mask bits 0-3 clear gives polled mode.
// - line_status bits 1 to 4 report receive errors of the received data.
// - line_status bits 5,6,7: transmit FIFO empty, transmitter idle, any FIFO error.
// - fifo_control bit 3 selects DMA mode 0 (reset) or block mode 1.
// - Mode 0: tx_ready_n low while transmit side empty; interrupt per single transfer.
// - Mode 0: rx_ready_n low whenever the receive holding register holds a character.
// - Mode 0: tx_ready_n low while transmit side empty, high after first load.
// - Mode 0: rx_ready_n low while any receive character held, high when none.
// - Mode 1: transmit interrupt while count below trigger; tx_ready_n low if space.
// - Mode 1: tx_ready_n high when transmit FIFO full, low otherwise.
// - Mode 1: receive interrupt at trigger; FIFO keeps filling until full.
// - Mode 1: rx_ready_n stays low while fill is above the trigger level.
// - Mode 1: rx_ready_n falls at trigger or time-out, rises only when empty.
// - Receive trigger field bits 7-6 set the receive interrupt threshold.
// - Transmit trigger field bits 5-4; in mode 1, interrupt when transmit count below level.
// - Writing fifo_control bit 2 flushes the transmit FIFO; bit self-clears.
// - Writing fifo_control bit 1 flushes the receive FIFO; bit self-clears.
// - fifo_control bit 0 enables FIFOs; 0 is single-character holding mode.
// - Other fifo_control bits are programmed only when bit 0 is written 1.
// - Receive trigger codes select 8, 16, 56 or 60 characters.
// - Transmit trigger codes select 8, 16, 32 or 56 characters.
`timescale 1ns/1ps
`default_nettype none
`include "ufdc_cfg.svh"

module ufdc_fifo_dma_control (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Host register side
  input  wire logic              fc_wr,
  input  wire ufdc_pkg::ufdc_byte_t fc_wdata,
  input  wire logic [3:0]        interrupt_mask,
  input  wire logic              host_wr_thr,
  input  wire ufdc_pkg::ufdc_byte_t host_wdata,
  input  wire logic              host_rd_rhr,
  input  wire logic              host_rd_lsr,
  output logic [7:0]             fifo_control,
  output ufdc_pkg::ufdc_byte_t   host_rdata,
  output logic [7:0]             line_status,
  output logic [7:0]             interrupt_source,
  output logic                   rx_int,
  output logic                   tx_int,
  // DMA ready pins
  output logic                   tx_ready_n,
  output logic                   rx_ready_n,
  // Receive shifter side
  input  wire logic              rx_push,
  input  wire ufdc_pkg::ufdc_byte_t rx_char,
  input  wire ufdc_pkg::ufdc_err_t rx_err,
  input  wire logic              rx_timeout,
  // Transmit shifter side
  input  wire logic              tx_pop,
  input  wire logic              tx_shift_empty,
  output logic                   tx_avail,
  output ufdc_pkg::ufdc_byte_t   tx_data,
  // Fill levels
  output ufdc_pkg::ufdc_count_t  rx_count,
  output ufdc_pkg::ufdc_count_t  tx_count
);
  import ufdc_pkg::*;

  function automatic ufdc_count_t step_count(input ufdc_count_t cnt, input logic up, input logic down);
    step_count = cnt;
    if (up && !down) begin
      step_count = cnt + 7'd1;
    end else if (down && !up) begin
      step_count = cnt - 7'd1;
    end
  endfunction : step_count

  function automatic ufdc_count_t rx_level(input logic [1:0] sel);
    unique case (sel)
      2'b00: rx_level = `UFDC_RXTRIG_0;
      2'b01: rx_level = `UFDC_RXTRIG_1;
      2'b10: rx_level = `UFDC_RXTRIG_2;
      2'b11: rx_level = `UFDC_RXTRIG_3;
    endcase
  endfunction : rx_level

  function automatic ufdc_count_t tx_level(input logic [1:0] sel);
    unique case (sel)
      2'b00: tx_level = `UFDC_TXTRIG_0;
      2'b01: tx_level = `UFDC_TXTRIG_1;
      2'b10: tx_level = `UFDC_TXTRIG_2;
      2'b11: tx_level = `UFDC_TXTRIG_3;
    endcase
  endfunction : tx_level

  // Priority is time-out, then receive trigger, then transmit; line status is not produced here.
  function automatic logic [5:0] isr_pick(input logic tout, input logic rx_req, input logic tx_req);
    if (tout) begin
      isr_pick = `UFDC_ISR_RXTOUT;
    end else if (rx_req) begin
      isr_pick = `UFDC_ISR_RXDATA;
    end else if (tx_req) begin
      isr_pick = `UFDC_ISR_TXEMPTY;
    end else begin
      isr_pick = `UFDC_ISR_NONE;
    end
  endfunction : isr_pick

  // Storage; memory words carry no reset, only the registers around them do.
  ufdc_byte_t     tx_mem [0:63];
  // Each receive word keeps its three error flags beside the character.
  logic [10:0]    rx_mem [0:63];

  ufdc_ptr_t      rx_wp;
  ufdc_ptr_t      rx_rp;
  ufdc_ptr_t      tx_wp;
  ufdc_ptr_t      tx_rp;
  ufdc_count_t    rx_errs;
  logic           overrun;

  ufdc_ptr_t      next_rx_wp;
  ufdc_ptr_t      next_rx_rp;
  ufdc_ptr_t      next_tx_wp;
  ufdc_ptr_t      next_tx_rp;
  ufdc_count_t    next_rx_count;
  ufdc_count_t    next_tx_count;
  ufdc_count_t    next_rx_errs;
  logic           next_overrun;
  logic [7:0]     next_fifo_control;
  ufdc_byte_t     next_host_rdata;
  ufdc_byte_t     next_tx_data;
  logic [7:0]     next_line_status;
  logic [7:0]     next_interrupt_source;
  logic           next_rx_int;
  logic           next_tx_int;
  logic           next_tx_ready_n;
  logic           next_rx_ready_n;

  logic           fifo_en;
  ufdc_dma_mode_e dma_mode;
  logic           block_mode;
  ufdc_count_t    capacity;
  ufdc_count_t    rx_trig;
  ufdc_count_t    tx_trig;
  logic           rx_clr;
  logic           tx_clr;
  logic           rx_we;
  logic           rx_re;
  logic           tx_we;
  logic           tx_re;
  logic           rx_full;
  logic           tx_full;
  logic           tx_low;
  logic           rx_has;
  logic           rx_at_trig;
  logic           rx_tout;
  ufdc_err_t      head_err;
  logic [5:0]     isr_code;

  assign fifo_en    = fifo_control[`UFDC_FC_EN];
  assign dma_mode   = fifo_control[`UFDC_FC_DMA] ? ufdc_dma_block : ufdc_dma_single;
  // Block mode only exists with the FIFOs on; holding mode always signals per character.
  assign block_mode = fifo_en && (dma_mode == ufdc_dma_block);
  assign capacity   = fifo_en ? `UFDC_DEPTH : `UFDC_HOLD_DEPTH;
  assign rx_trig    = rx_level(fifo_control[`UFDC_FC_RXTRIG_HI:`UFDC_FC_RXTRIG_LO]);
  assign tx_trig    = tx_level(fifo_control[`UFDC_FC_TXTRIG_HI:`UFDC_FC_TXTRIG_LO]);
  assign rx_has     = (rx_count != 7'd0);
  assign rx_full    = (rx_count >= capacity);
  assign tx_full    = (tx_count >= capacity);
  assign tx_low     = (tx_count < tx_trig);
  assign rx_at_trig = (rx_count >= rx_trig);
  assign rx_tout    = rx_timeout && rx_has;
  assign head_err   = rx_has ? rx_mem[rx_rp][10:8] : 3'h0;
  assign tx_avail   = (tx_count != 7'd0);

  // Control register write and flush requests.
  // Leaving FIFO mode flushes both sides, since holding mode keeps one character only.
  always_comb begin
    next_fifo_control = fifo_control;
    rx_clr = 1'b0;
    tx_clr = 1'b0;
    if (fc_wr) begin
      if (fc_wdata[`UFDC_FC_EN]) begin
        next_fifo_control = fc_wdata & `UFDC_FC_SELFCLR;
        // Turning the FIFOs on from holding mode also starts from empty.
        rx_clr = fc_wdata[`UFDC_FC_RXCLR] || !fifo_en;
        tx_clr = fc_wdata[`UFDC_FC_TXCLR] || !fifo_en;
      end else begin
        next_fifo_control[`UFDC_FC_EN] = 1'b0;
        rx_clr = fifo_en;
        tx_clr = fifo_en;
      end
    end
  end

  // FIFO pointers, fill counts and the words handed to each side.
  always_comb begin
    // A flush in the same cycle as a push or pop wins, so no stale entry survives.
    rx_we = rx_push && !rx_full && !rx_clr;
    rx_re = host_rd_rhr && rx_has && !rx_clr;
    tx_we = host_wr_thr && !tx_full && !tx_clr;
    tx_re = tx_pop && tx_avail && !tx_clr;
    next_rx_wp    = rx_clr ? 6'h00 : (rx_we ? rx_wp + 6'h01 : rx_wp);
    next_rx_rp    = rx_clr ? 6'h00 : (rx_re ? rx_rp + 6'h01 : rx_rp);
    next_tx_wp    = tx_clr ? 6'h00 : (tx_we ? tx_wp + 6'h01 : tx_wp);
    next_tx_rp    = tx_clr ? 6'h00 : (tx_re ? tx_rp + 6'h01 : tx_rp);
    next_rx_count = rx_clr ? 7'd0 : step_count(rx_count, rx_we, rx_re);
    next_tx_count = tx_clr ? 7'd0 : step_count(tx_count, tx_we, tx_re);
    next_rx_errs  = rx_clr ? 7'd0 : step_count(rx_errs, rx_we && (rx_err != 3'h0), rx_re && (head_err != 3'h0));
    // Overrun set wins over a clearing status read in the same cycle.
    next_overrun  = (rx_push && rx_full && !rx_clr) || (overrun && !host_rd_lsr);
    next_host_rdata = rx_re ? rx_mem[rx_rp][7:0] : host_rdata;
    next_tx_data    = tx_re ? tx_mem[tx_rp] : tx_data;
  end

  // Status, interrupts and DMA ready pins, all one clock behind the counts.
  always_comb begin
    next_rx_int = interrupt_mask[0] && (fifo_en ? rx_at_trig : rx_has);
    next_tx_int = interrupt_mask[1] && (block_mode ? tx_low : !tx_avail);
    isr_code    = isr_pick(interrupt_mask[0] && fifo_en && rx_tout, next_rx_int, next_tx_int);
    next_interrupt_source = {fifo_en, fifo_en, isr_code};
    // These bits are valid whatever the mask holds, which is what makes polling work.
    next_line_status[0]   = rx_has;
    next_line_status[1]   = overrun;
    next_line_status[4:2] = head_err;
    next_line_status[5]   = !tx_avail;
    next_line_status[6]   = !tx_avail && tx_shift_empty;
    next_line_status[7]   = fifo_en && (rx_errs != 7'd0);
    if (block_mode) begin
      next_tx_ready_n = (tx_count == `UFDC_DEPTH);
      // Held low from trigger or time-out until drained, so it stays low above the level.
      next_rx_ready_n = !(rx_has && (rx_at_trig || rx_tout || !rx_ready_n));
    end else begin
      next_tx_ready_n = tx_avail;
      next_rx_ready_n = !rx_has;
    end
  end

  // Each memory has one write port; reads go through the registered head capture.
  always_ff @(posedge core_clk) begin
    if (rx_we) begin
      rx_mem[rx_wp] <= {rx_err, rx_char};
    end
  end

  always_ff @(posedge core_clk) begin
    if (tx_we) begin
      tx_mem[tx_wp] <= host_wdata;
    end
  end

  // The control register is its own group, so a FIFO flush never touches its fields.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_control <= `UFDC_FC_RESET;
    end else begin
      fifo_control <= next_fifo_control;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wp            <= 6'h00;
      rx_rp            <= 6'h00;
      tx_wp            <= 6'h00;
      tx_rp            <= 6'h00;
      rx_count         <= 7'd0;
      tx_count         <= 7'd0;
      rx_errs          <= 7'd0;
      overrun          <= 1'b0;
      host_rdata       <= 8'h00;
      tx_data          <= 8'h00;
    end else begin
      rx_wp            <= next_rx_wp;
      rx_rp            <= next_rx_rp;
      tx_wp            <= next_tx_wp;
      tx_rp            <= next_tx_rp;
      rx_count         <= next_rx_count;
      tx_count         <= next_tx_count;
      rx_errs          <= next_rx_errs;
      overrun          <= next_overrun;
      host_rdata       <= next_host_rdata;
      tx_data          <= next_tx_data;
    end
  end

  // Status and pins reset to idle: transmitter ready, receiver not ready.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_status      <= `UFDC_LS_RESET;
      interrupt_source <= {2'b00, `UFDC_ISR_NONE};
      rx_int           <= 1'b0;
      tx_int           <= 1'b0;
      tx_ready_n       <= 1'b0;
      rx_ready_n       <= 1'b1;
    end else begin
      line_status      <= next_line_status;
      interrupt_source <= next_interrupt_source;
      rx_int           <= next_rx_int;
      tx_int           <= next_tx_int;
      tx_ready_n       <= next_tx_ready_n;
      rx_ready_n       <= next_rx_ready_n;
    end
  end

endmodule : ufdc_fifo_dma_control
`default_nettype wire

/* hw/ufdc_pkg.sv */
// Types shared by the FIFO control and DMA ready block.
`default_nettype none
package ufdc_pkg;
  typedef logic [6:0] ufdc_count_t;
  typedef logic [5:0] ufdc_ptr_t;
  typedef logic [7:0] ufdc_byte_t;
  typedef logic [2:0] ufdc_err_t;
  typedef enum logic {ufdc_dma_single, ufdc_dma_block} ufdc_dma_mode_e;
endpackage : ufdc_pkg
`default_nettype wire

/* testbench/tb_uart_fifo_dma_control.sv */
// Self-checking testbench for the FIFO control and DMA ready block.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_dma_control;
  import ufdc_pkg::*;
  logic core_clk, sys_rst, fc_wr, host_wr_thr, host_rd_rhr, host_rd_lsr, rx_int, tx_int;
  logic tx_ready_n, rx_ready_n, rx_push, rx_timeout, tx_pop, tx_shift_empty, tx_avail;
  logic [3:0] interrupt_mask;
  logic [7:0] fc_wdata, host_wdata, fifo_control, line_status, interrupt_source;
  ufdc_byte_t host_rdata, tx_data, rx_char;
  ufdc_err_t rx_err;
  ufdc_count_t rx_count, tx_count;
  int n_fail, comparisons;
  int rt[4] = '{8, 16, 56, 60};
  int tt[4] = '{8, 16, 32, 56};
  ufdc_host host (.core_clk, .fc_wr, .fc_wdata, .interrupt_mask, .host_wr_thr, .host_wdata, .host_rd_rhr, .host_rd_lsr);
  ufdc_fifo_dma_control DUT (.core_clk, .sys_rst, .fc_wr, .fc_wdata, .interrupt_mask, .host_wr_thr, .host_wdata,
    .host_rd_rhr, .host_rd_lsr, .fifo_control, .host_rdata, .line_status, .interrupt_source, .rx_int, .tx_int,
    .tx_ready_n, .rx_ready_n, .rx_push, .rx_char, .rx_err, .rx_timeout, .tx_pop, .tx_shift_empty, .tx_avail,
    .tx_data, .rx_count, .tx_count);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Ready pins and status lag the counts by one edge, so two edges are always enough.
  task automatic wt;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : wt
  task automatic rx_in(input int n, input logic [2:0] e);
    @(posedge core_clk);
    rx_push <= 1'b1;
    rx_err <= e;
    for (int i = 0; i < n; i++) begin
      rx_char <= 8'h5a + i[7:0];
      @(posedge core_clk);
    end
    rx_push <= 1'b0;
    rx_err <= 3'h0;
  endtask : rx_in
  task automatic pop;
    @(posedge core_clk);
    tx_pop <= 1'b1;
    @(posedge core_clk);
    tx_pop <= 1'b0;
  endtask : pop
  task automatic t_reset;
    wt;
    chk("fifo_control", 8'h00, fifo_control);
    chk("ready pins", 8'h01, {tx_ready_n, rx_ready_n});
    chk("line_status", 8'h60, line_status);
    $display("test reset done");
  endtask : t_reset
  task automatic t_hold;
    rx_in(1, 3'h0);
    wt;
    chk("rx_ready_n", 8'h00, rx_ready_n);
    chk("data ready", 8'h01, line_status[0]);
    host.rd_rhr(1);
    wt;
    chk("host_rdata", 8'h5a, host_rdata);
    chk("rx_ready_n", 8'h01, rx_ready_n);
    host.put_thr(2);
    wt;
    chk("tx_count", 8'h01, tx_count);
    chk("tx_avail", 8'h01, tx_avail);
    chk("tx_ready_n", 8'h01, tx_ready_n);
    pop;
    wt;
    chk("tx_ready_n", 8'h00, tx_ready_n);
    $display("test holding mode done");
  endtask : t_hold
  task automatic t_rx_trig;
    host.set_mask(4'h1);
    for (int c = 0; c < 4; c++) begin
      host.write_fc({c[1:0], 6'h0b});
      rx_in(rt[c] - 1, 3'h0);
      wt;
      chk("fifo_control", {c[1:0], 6'h09}, fifo_control);
      chk("rx below", 8'h01, {rx_int, rx_ready_n});
      rx_in(1, 3'h0);
      wt;
      chk("rx at trigger", 8'h02, {rx_int, rx_ready_n});
      chk("interrupt_source", 8'hc4, interrupt_source);
    end
    rx_in(5, 3'h0);
    wt;
    chk("rx_count", 8'h40, rx_count);
    chk("overrun", 8'h01, line_status[1]);
    host.rd_lsr;
    host.rd_rhr(5);
    wt;
    chk("overrun", 8'h00, line_status[1]);
    chk("rx under", 8'h00, {rx_int, rx_ready_n});
    chk("interrupt_source", 8'hc1, interrupt_source);
    $display("test receive trigger done");
  endtask : t_rx_trig
  task automatic t_timeout;
    host.write_fc(8'h0b);
    rx_in(3, 3'h0);
    wt;
    chk("rx before time-out", 8'h01, {rx_int, rx_ready_n});
    @(posedge core_clk);
    rx_timeout <= 1'b1;
    wt;
    chk("rx_ready_n", 8'h00, rx_ready_n);
    chk("interrupt_source", 8'hcc, interrupt_source);
    @(posedge core_clk);
    rx_timeout <= 1'b0;
    wt;
    chk("rx_ready_n", 8'h00, rx_ready_n);
    host.rd_rhr(3);
    wt;
    chk("host_rdata", 8'h5c, host_rdata);
    chk("rx drained", 8'h01, {rx_int, rx_ready_n});
    $display("test receive time-out done");
  endtask : t_timeout
  task automatic t_tx_trig;
    host.set_mask(4'h2);
    for (int c = 0; c < 4; c++) begin
      host.write_fc({2'b00, c[1:0], 4'hd});
      host.put_thr(tt[c] - 1);
      wt;
      chk("tx below", 8'h02, {tx_int, tx_ready_n});
      host.put_thr(1);
      wt;
      chk("tx_int", 8'h00, tx_int);
    end
    host.put_thr(9);
    wt;
    chk("tx full", 8'hc0, {tx_ready_n, tx_count});
    pop;
    pop;
    wt;
    chk("tx_ready_n", 8'h00, tx_ready_n);
    chk("tx_data", 8'h01, tx_data);
    $display("test transmit trigger done");
  endtask : t_tx_trig
  task automatic t_status;
    host.set_mask(4'h0);
    host.write_fc(8'hf8);
    @(posedge core_clk);
    tx_shift_empty <= 1'b0;
    wt;
    chk("fifo_control", 8'h38, fifo_control);
    chk("tx empty bits", 8'h01, line_status[6:5]);
    host.write_fc(8'h01);
    rx_in(1, 3'h0);
    rx_in(1, 3'h2);
    wt;
    chk("error flag", 8'h01, line_status[7]);
    chk("head errors", 8'h00, line_status[4:1]);
    host.rd_rhr(1);
    wt;
    chk("head errors", 8'h04, line_status[4:1]);
    chk("rx_ready_n", 8'h00, rx_ready_n);
    $display("test status done");
  endtask : t_status
  initial begin
    {rx_push, rx_timeout, tx_pop, rx_err, n_fail, comparisons} = '0;
    rx_char = 8'h5a;
    tx_shift_empty = 1'b1;
    sys_rst = 1'b1;
    t_reset;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_hold;
    t_rx_trig;
    t_timeout;
    t_tx_trig;
    t_status;
    report_and_stop;
  end
  initial begin
    #200us;
    n_fail++;
    report_and_stop;
  end
endmodule : tb_uart_fifo_dma_control
`default_nettype wire

/* testbench/ufdc_chk_asserts.sv */
// Checker for the FIFO control and DMA ready block.
`timescale 1ns/1ps
`default_nettype none
module ufdc_chk (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  // Watched ports
  input wire logic                  fc_wr,
  input wire ufdc_pkg::ufdc_byte_t  fc_wdata,
  input wire logic [3:0]            interrupt_mask,
  input wire logic [7:0]            fifo_control,
  input wire logic [7:0]            line_status,
  input wire logic [7:0]            interrupt_source,
  input wire logic                  rx_int,
  input wire logic                  tx_ready_n,
  input wire logic                  rx_ready_n,
  input wire logic                  rx_timeout,
  input wire ufdc_pkg::ufdc_count_t rx_count,
  input wire ufdc_pkg::ufdc_count_t tx_count
);
  import ufdc_pkg::*;
  logic       blk;
  logic [6:0] rtrig;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  assign blk = fifo_control[0] & fifo_control[3];
  assign rtrig = fifo_control[7] ? (fifo_control[6] ? 7'h3c : 7'h38) : (fifo_control[6] ? 7'h10 : 7'h08);
  a_rx_rdy_single: assert property (!blk |=> rx_ready_n == ($past(rx_count) == 7'h00))
    else $error("rx_ready_n wrong in single mode");
  a_tx_rdy_single: assert property (!blk |=> tx_ready_n == ($past(tx_count) != 7'h00))
    else $error("tx_ready_n wrong in single mode");
  a_tx_rdy_block: assert property (blk |=> tx_ready_n == ($past(tx_count) == 7'h40))
    else $error("tx_ready_n wrong in block mode");
  a_rx_rdy_fall: assert property (blk && (rx_count >= rtrig || rx_timeout && rx_count != 0) |=> !rx_ready_n)
    else $error("rx_ready_n did not fall");
  a_rx_rdy_hold: assert property (blk && !rx_ready_n && rx_count != 7'h00 |=> !rx_ready_n)
    else $error("rx_ready_n rose with data held");
  a_rx_int_trig: assert property (fifo_control[0] |=>
    rx_int == ($past(interrupt_mask[0]) && $past(rx_count) >= $past(rtrig)))
    else $error("rx_int does not follow trigger");
  a_isr_rx_code: assert property (rx_int |-> interrupt_source[5:0] inside {6'h04, 6'h0c})
    else $error("interrupt_source lacks receive code");
  a_data_ready: assert property (1'b1 |=> line_status[0] == ($past(rx_count) != 7'h00))
    else $error("data ready bit wrong");
  a_fc_write: assert property (fc_wr && fc_wdata[0] |=> fifo_control == ($past(fc_wdata) & 8'hf9))
    else $error("fifo_control write wrong");
  c_rx_block: cover property (blk && !rx_ready_n);
  c_tx_full: cover property (tx_count == 7'h40);
  c_rx_flush: cover property (fc_wr && fc_wdata[0] && fc_wdata[1]);
  c_rx_timeout: cover property (blk && rx_timeout && rx_count != 7'h00);
endmodule : ufdc_chk
bind ufdc_fifo_dma_control ufdc_chk u_chk (.core_clk, .sys_rst, .fc_wr, .fc_wdata, .interrupt_mask, .fifo_control,
  .line_status, .interrupt_source, .rx_int, .tx_ready_n, .rx_ready_n, .rx_timeout, .rx_count, .tx_count);
`default_nettype wire

/* testbench/ufdc_host.sv */
// Host-side model that programs the FIFO control and moves characters.
`timescale 1ns/1ps
`default_nettype none
module ufdc_host (
  // Clock
  input wire logic       core_clk,
  // Host strobes and data
  output var logic       fc_wr,
  output var logic [7:0] fc_wdata,
  output var logic [3:0] interrupt_mask,
  output var logic       host_wr_thr,
  output var logic [7:0] host_wdata,
  output var logic       host_rd_rhr,
  output var logic       host_rd_lsr
);
  initial begin
    {fc_wr, fc_wdata, interrupt_mask, host_wr_thr, host_wdata, host_rd_rhr, host_rd_lsr} = '0;
  end
  task automatic set_mask(input logic [3:0] m);
    @(posedge core_clk);
    interrupt_mask <= m;
  endtask : set_mask
  // Released data is inverted so a stale value is never mistaken for a fresh one.
  task automatic write_fc(input logic [7:0] d);
    @(posedge core_clk);
    fc_wr <= 1'b1;
    fc_wdata <= d;
    @(posedge core_clk);
    fc_wr <= 1'b0;
    fc_wdata <= ~d;
  endtask : write_fc
  task automatic put_thr(input int n);
    @(posedge core_clk);
    host_wr_thr <= 1'b1;
    for (int i = 0; i < n; i++) begin
      host_wdata <= i[7:0];
      @(posedge core_clk);
    end
    host_wr_thr <= 1'b0;
    host_wdata <= ~host_wdata;
  endtask : put_thr
  task automatic rd_rhr(input int n);
    @(posedge core_clk);
    host_rd_rhr <= 1'b1;
    repeat (n) @(posedge core_clk);
    host_rd_rhr <= 1'b0;
  endtask : rd_rhr
  task automatic rd_lsr;
    @(posedge core_clk);
    host_rd_lsr <= 1'b1;
    @(posedge core_clk);
    host_rd_lsr <= 1'b0;
  endtask : rd_lsr
endmodule : ufdc_host
`default_nettype wire
